// ### design/latch_bank.sv
// Per-common segment latches with a masked write and a registered read.
`default_nettype none

module latch_bank #(
	parameter int WIDTH = 80,
	parameter int DEPTH = 5
) (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Latch port.
	latch_if.store    port_if
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rdata;
	} bank_t;

	bank_t st;
	bank_t next_st;

	always_comb begin
		next_st = st;
		for (int k = 0; k < DEPTH; k++) begin
			if (port_if.we && port_if.wmask[k]) begin
				next_st.mem[k] = port_if.wdata; // [RULE_06]
			end
		end
		next_st.rdata = (int'(port_if.raddr) < DEPTH) ? st.mem[port_if.raddr] : '0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign port_if.rdata = st.rdata;

	for (genvar g = 0; g < DEPTH; g++) begin : g_chk
		property p_selected_latch_written;
			@(posedge clk_i) disable iff (rst_i)
			port_if.we && port_if.wmask[g] |=> st.mem[g] == $past(port_if.wdata);
		endproperty
		a_selected_latch_written: assert property (p_selected_latch_written) // [RULE_06]
			else $error("A selected latch did not take the segment field.");

		property p_unselected_latch_kept;
			@(posedge clk_i) disable iff (rst_i)
			!(port_if.we && port_if.wmask[g]) |=> $stable(st.mem[g]);
		endproperty
		a_unselected_latch_kept: assert property (p_unselected_latch_kept) // [RULE_05]
			else $error("An unselected latch changed.");
	end

endmodule

`default_nettype wire

// ### design/latch_if.sv
// Write and read port between the driver core and its latch bank.
`default_nettype none

interface latch_if #(
	parameter int WIDTH = 80,
	parameter int DEPTH = 5
);
	logic                     we;
	logic [DEPTH-1:0]         wmask;
	logic [WIDTH-1:0]         wdata;
	logic [$clog2(DEPTH)-1:0] raddr;
	logic [WIDTH-1:0]         rdata;

	modport writer (output we, output wmask, output wdata, output raddr, input rdata);
	modport store  (input we, input wmask, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ### design/lcd_pkg.sv
// Shared constants for the multiplexed LCD segment driver.
`default_nettype none

package lcd_pkg;

	// Serial word layout: segment field high, dummy bits, select field low.
	localparam int SHIFT_BITS = 88;
	localparam int SEG_COUNT  = 80;
	localparam int COM_COUNT  = 5;
	localparam int DUMMY_BITS = 3;
	localparam int SEL_POS    = 0;
	localparam int SEG_POS    = SEL_POS + COM_COUNT + DUMMY_BITS;

	// Drive level codes; equal bits mean a full level, unequal bits a mid level.
	localparam logic [1:0] LVL_GND   = 2'h0;
	localparam logic [1:0] LVL_LOWER = 2'h1;
	localparam logic [1:0] LVL_UPPER = 2'h2;
	localparam logic [1:0] LVL_HIGH  = 2'h3;

	// Duty modes held in the control register.
	localparam logic [1:0] MODE_DUTY3 = 2'h0;
	localparam logic [1:0] MODE_DUTY4 = 2'h1;
	localparam logic [1:0] MODE_DUTY5 = 2'h2;

	// Register byte offsets.
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_OSC_DIV = 4'h4;
	localparam logic [3:0] ADDR_STATUS  = 4'h8;

	// Field positions.
	localparam int CTRL_MODE_POS    = 0;
	localparam int STATUS_COM_POS   = 0;
	localparam int STATUS_PHASE_POS = 4;
	localparam int STATUS_BLANK_POS = 5;
	localparam int STATUS_LOAD_POS  = 6;
	localparam int STATUS_COUNT_POS = 16;

	// Reset value and divider minimum.
	localparam logic [1:0]  CTRL_MODE_RESET = MODE_DUTY5;
	localparam logic [15:0] OSC_DIV_MIN     = 16'h0001;

	// Timing: system clock and the oscillator rate that the divider models.
	localparam int CLK_FREQ_HZ    = 32'h05F5_E100;
	localparam int OSC_FREQ_HZ    = 32'h0000_1F40;
	localparam int OSC_DIV_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
	localparam int TICKS_PER_SLOT = 16;
	localparam int TICKS_PER_HALF = TICKS_PER_SLOT / 2;

endpackage

`default_nettype wire

// ### design/lcd_seg_driver.sv
// Multiplexed LCD segment driver: serial load, per-common latches, duty scan and level coding.
//
// Contract
// RULE_01: Host keeps blank low after power-up until the first full word is latched.
// RULE_02: Every rising serial clock edge shifts one data bit into the 88-bit shift register.
// RULE_03: While load is high the segment field is copied into the selected 80-bit latch.
// RULE_04: Each serial word carries an 80-bit segment field and a five-bit select field.
// RULE_05: Select bits map one per common; bit n routes data to the latch of common n.
// RULE_06: Several set select bits write the same segment field into every chosen latch.
// RULE_07: Dummy bits of the serial word are ignored and may hold any value.
// RULE_08: Selected common swings full high and ground; segments oppose at full or mid level.
// RULE_09: Frame frequency equals oscillator frequency times duty divided by 16.
// RULE_10: Three drive modes scan three, four or five commons per frame.
// RULE_11: Data sampled at rising serial clock; segment bits first, select last, load after.
// RULE_12: Latch bit 1 lights the segment, 0 leaves it dark; blank low darkens all.
`default_nettype none

module lcd_seg_driver #(
	parameter logic [15:0] OSC_DIV_RESET = 16'(lcd_pkg::OSC_DIV_CYCLES)
) (
	// System clock and reset.
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_i,
	// Wishbone register slave.
	input  wire logic                                 wb_cyc_i,
	input  wire logic                                 wb_stb_i,
	input  wire logic                                 wb_we_i,
	input  wire logic [3:0]                           wb_adr_i,
	input  wire logic [3:0]                           wb_sel_i,
	input  wire logic [31:0]                          wb_dat_i,
	output logic      [31:0]                          wb_dat_o,
	output logic                                      wb_ack_o,
	// Serial link from the host.
	input  wire logic                                 serial_clk_i,
	input  wire logic                                 serial_data_i,
	input  wire logic                                 load_i,
	input  wire logic                                 blank_n_i,
	// Drive level codes.
	output logic      [lcd_pkg::COM_COUNT-1:0][1:0]   common_out_o,
	output logic      [lcd_pkg::SEG_COUNT-1:0][1:0]   segment_out_o
);

	localparam int         SB        = lcd_pkg::SHIFT_BITS;
	localparam int         NSEG      = lcd_pkg::SEG_COUNT;
	localparam int         NCOM      = lcd_pkg::COM_COUNT;
	localparam logic [2:0] HALF_LAST = 3'(lcd_pkg::TICKS_PER_HALF - 1);

	// Link-side state. The word is pure data, fully rewritten before each load.
	typedef struct packed {
		logic [SB-1:0] shift;
	} link_t;

	typedef struct packed {
		logic                      load_meta;
		logic                      load_sync;
		logic                      load_seen;
		logic                      blank_meta;
		logic                      blank_n_sync;
		logic [1:0]                mode;
		logic [15:0]               osc_div;
		logic [15:0]               osc_cnt;
		logic [2:0]                half_cnt;
		logic                      phase_hi;
		logic [2:0]                com;
		logic [2:0]                rd_com;
		logic                      rd_phase;
		logic [15:0]               load_count;
		logic                      ack;
		logic [31:0]               dat;
		logic [NCOM-1:0][1:0]      common_out;
		logic [NSEG-1:0][1:0]      segment_out;
	} core_t;

	link_t link;
	link_t next_link;
	core_t st;
	core_t next_st;

	logic  tick;
	logic  slot_end;
	logic  mode_wr;

	latch_if #(.WIDTH(NSEG), .DEPTH(NCOM)) lat ();

	latch_bank #(
		.WIDTH (NSEG),
		.DEPTH (NCOM)
	) u_bank (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.port_if (lat.store)
	);

	function automatic logic [2:0] num_commons(input logic [1:0] mode);
		unique case (mode)
			lcd_pkg::MODE_DUTY3: num_commons = 3'h3;
			lcd_pkg::MODE_DUTY4: num_commons = 3'h4;
			default:             num_commons = 3'h5;
		endcase
	endfunction

	function automatic logic [1:0] common_level(input logic selected, input logic hi);
		if (selected) begin
			common_level = hi ? lcd_pkg::LVL_HIGH : lcd_pkg::LVL_GND;
		end else begin
			common_level = hi ? lcd_pkg::LVL_LOWER : lcd_pkg::LVL_UPPER;
		end
	endfunction

	function automatic logic [1:0] segment_level(input logic lit, input logic hi);
		if (lit) begin
			segment_level = hi ? lcd_pkg::LVL_GND : lcd_pkg::LVL_HIGH;
		end else begin
			segment_level = hi ? lcd_pkg::LVL_UPPER : lcd_pkg::LVL_LOWER;
		end
	endfunction

	// The first segment bit sent ends up in the top bit of the word.
	function automatic logic [NSEG-1:0] segment_field(input logic [SB-1:0] w);
		segment_field = '0;
		for (int n = 0; n < NSEG; n++) begin
			segment_field[n] = w[SB-1-n];
		end
	endfunction

	// Select bit one arrives before select bit five, so it sits higher.
	function automatic logic [NCOM-1:0] select_field(input logic [SB-1:0] w);
		select_field = '0;
		for (int k = 0; k < NCOM; k++) begin
			select_field[k] = w[lcd_pkg::SEL_POS + NCOM - 1 - k];
		end
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		merge16 = old;
		if (sel[0]) begin
			merge16[7:0] = d[7:0];
		end
		if (sel[1]) begin
			merge16[15:8] = d[15:8];
		end
	endfunction

	// Serial link domain.
	always_comb begin
		next_link       = link;
		next_link.shift = {link.shift[SB-2:0], serial_data_i}; // [RULE_02] [RULE_11]
	end

	always_ff @(posedge serial_clk_i) begin
		link <= next_link;
	end

	// The host stops the serial clock well before raising load and keeps it still
	// while load is high, so the word is static whenever the synchronised load is
	// seen; that is what makes reading it here a safe crossing.
	assign lat.we    = st.load_sync; // [RULE_03]
	assign lat.wmask = select_field(link.shift); // [RULE_05] [RULE_06]
	assign lat.wdata = segment_field(link.shift); // [RULE_04] [RULE_07]
	assign lat.raddr = st.com;

	always_comb begin
		next_st  = st;
		tick     = 1'b0;
		slot_end = 1'b0;
		mode_wr  = 1'b0;

		next_st.load_meta    = load_i;
		next_st.load_sync    = st.load_meta;
		next_st.load_seen    = st.load_sync;
		next_st.blank_meta   = blank_n_i;
		next_st.blank_n_sync = st.blank_meta;
		if (st.load_sync && !st.load_seen) begin
			next_st.load_count = st.load_count + 16'h0001;
		end

		// Oscillator model and scan: 16 ticks per common, split into two halves.
		tick = (st.osc_cnt >= st.osc_div - 16'h0001);
		next_st.osc_cnt = tick ? 16'h0000 : st.osc_cnt + 16'h0001;
		if (tick) begin
			next_st.half_cnt = st.half_cnt + 3'h1;
			if (st.half_cnt == HALF_LAST) begin
				next_st.phase_hi = !st.phase_hi;
				if (!st.phase_hi) begin
					slot_end    = 1'b1;
					next_st.com = (st.com == num_commons(st.mode) - 3'h1) ? 3'h0 : st.com + 3'h1; // [RULE_09] [RULE_10]
				end
			end
		end

		// Wishbone: one wait state, then a single-cycle acknowledge.
		next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
		next_st.dat = '0;
		if (next_st.ack) begin
			unique case (wb_adr_i)
				lcd_pkg::ADDR_CTRL: begin
					next_st.dat[lcd_pkg::CTRL_MODE_POS +: 2] = st.mode;
					if (wb_we_i && wb_sel_i[0]) begin
						mode_wr      = 1'b1;
						next_st.mode = (wb_dat_i[lcd_pkg::CTRL_MODE_POS +: 2] == 2'h3) ?
							lcd_pkg::MODE_DUTY5 : wb_dat_i[lcd_pkg::CTRL_MODE_POS +: 2]; // [RULE_10]
					end
				end
				lcd_pkg::ADDR_OSC_DIV: begin
					next_st.dat[15:0] = st.osc_div;
					if (wb_we_i) begin
						next_st.osc_div = merge16(st.osc_div, wb_dat_i, wb_sel_i);
						if (next_st.osc_div < lcd_pkg::OSC_DIV_MIN) begin
							next_st.osc_div = lcd_pkg::OSC_DIV_MIN;
						end
					end
				end
				lcd_pkg::ADDR_STATUS: begin
					next_st.dat[lcd_pkg::STATUS_COM_POS +: 3]    = st.com;
					next_st.dat[lcd_pkg::STATUS_PHASE_POS]       = st.phase_hi;
					next_st.dat[lcd_pkg::STATUS_BLANK_POS]       = !st.blank_n_sync;
					next_st.dat[lcd_pkg::STATUS_LOAD_POS]        = st.load_sync;
					next_st.dat[lcd_pkg::STATUS_COUNT_POS +: 16] = st.load_count;
				end
				default: begin
					next_st.dat = '0;
				end
			endcase
		end

		// A mode change restarts the frame so the scan index is never out of range.
		if (mode_wr) begin
			next_st.com      = 3'h0;
			next_st.phase_hi = 1'b1;
			next_st.half_cnt = 3'h0;
			next_st.osc_cnt  = 16'h0000;
		end

		// Output stage, aligned with the registered latch read of the same common.
		next_st.rd_com   = st.com;
		next_st.rd_phase = st.phase_hi;
		for (int k = 0; k < NCOM; k++) begin
			next_st.common_out[k] = common_level(3'(k) == st.rd_com, st.rd_phase); // [RULE_08]
		end
		for (int n = 0; n < NSEG; n++) begin
			next_st.segment_out[n] = segment_level(lat.rdata[n] && st.blank_n_sync, st.rd_phase); // [RULE_08] [RULE_12]
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st          <= '0;
			st.mode     <= lcd_pkg::CTRL_MODE_RESET;
			st.osc_div  <= OSC_DIV_RESET;
			st.phase_hi <= 1'b1;
			st.rd_phase <= 1'b1;
			// Blank reads as asserted until the pin has been sampled, so the glass stays dark.
			st.blank_n_sync <= 1'b0; // [RULE_01]
		end else begin
			st <= next_st;
		end
	end

	assign wb_ack_o      = st.ack;
	assign wb_dat_o      = st.dat;
	assign common_out_o  = st.common_out;
	assign segment_out_o = st.segment_out;

	// Helper logic read only by the checks below.
	logic [NCOM-1:0] com_full;
	logic            com_high_seen;
	logic            seg_lsb_any;
	logic            seg_all_mid;
	logic [4:0]      slot_ticks;

	always_comb begin
		com_high_seen = 1'b0;
		seg_lsb_any   = 1'b0;
		seg_all_mid   = 1'b1;
		for (int k = 0; k < NCOM; k++) begin
			com_full[k]   = (st.common_out[k][1] == st.common_out[k][0]);
			com_high_seen = com_high_seen || (st.common_out[k] == lcd_pkg::LVL_HIGH);
		end
		for (int n = 0; n < NSEG; n++) begin
			seg_lsb_any = seg_lsb_any || st.segment_out[n][0];
			seg_all_mid = seg_all_mid && (st.segment_out[n][1] != st.segment_out[n][0]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || mode_wr || slot_end) begin
			slot_ticks <= 5'h00;
		end else if (tick) begin
			slot_ticks <= slot_ticks + 5'h01;
		end
	end

	sequence s_load_held;
		load_i [*3];
	endsequence

	sequence s_load_idle;
		!load_i [*3];
	endsequence

	property p_shift_order;
		@(posedge serial_clk_i) disable iff (rst_i)
		1'b1 |=> ##1 link.shift[1:0] == {$past(serial_data_i, 2), $past(serial_data_i)};
	endproperty
	a_shift_order: assert property (p_shift_order) // [RULE_02] [RULE_11]
		else $error("Serial bits did not enter the word in arrival order.");

	property p_load_writes;
		@(posedge clk_i) disable iff (rst_i)
		s_load_held |-> lat.we ##1 (lat.we || !load_i);
	endproperty
	a_load_writes: assert property (p_load_writes) // [RULE_03]
		else $error("Latch write missing while load was held high.");

	property p_idle_no_write;
		@(posedge clk_i) disable iff (rst_i)
		s_load_idle |-> !lat.we;
	endproperty
	a_idle_no_write: assert property (p_idle_no_write) // [RULE_03]
		else $error("Latch written while load was low.");

	property p_select_decode;
		@(posedge clk_i) disable iff (rst_i)
		lat.we |-> lat.wmask[0] == link.shift[NCOM - 1] && lat.wmask[NCOM - 1] == link.shift[0]
			&& lat.wdata[0] == link.shift[SB - 1];
	endproperty
	a_select_decode: assert property (p_select_decode) // [RULE_05] [RULE_04]
		else $error("Select or segment field taken from the wrong bit position.");

	property p_one_common_full;
		@(posedge clk_i) disable iff (rst_i)
		$rose(st.rd_phase) |=> $onehot(com_full) ##1 $onehot(com_full);
	endproperty
	a_one_common_full: assert property (p_one_common_full) // [RULE_08]
		else $error("Not exactly one common at a full level.");

	property p_segments_oppose;
		@(posedge clk_i) disable iff (rst_i)
		com_high_seen |-> !seg_lsb_any;
	endproperty
	a_segments_oppose: assert property (p_segments_oppose) // [RULE_08]
		else $error("A segment sits at a high-side level while the common is high.");

	property p_slot_length;
		@(posedge clk_i) disable iff (rst_i)
		slot_end && !mode_wr && !$past(mode_wr) |-> slot_ticks == 5'(lcd_pkg::TICKS_PER_SLOT - 1);
	endproperty
	a_slot_length: assert property (p_slot_length) // [RULE_09]
		else $error("A common slot did not last sixteen oscillator ticks.");

	property p_com_in_range;
		@(posedge clk_i) disable iff (rst_i)
		st.com < num_commons(st.mode);
	endproperty
	a_com_in_range: assert property (p_com_in_range) // [RULE_10]
		else $error("Scan index beyond the commons of the current duty.");

	property p_blank_dark;
		@(posedge clk_i) disable iff (rst_i)
		!blank_n_i [*3] |=> seg_all_mid;
	endproperty
	a_blank_dark: assert property (p_blank_dark) // [RULE_12]
		else $error("A segment was lit while blank was low.");

endmodule

`default_nettype wire

// ### testbench/lcd_host_model.sv
// Host side of the serial display link: shifts words in, strobes load and drives blank.
`default_nettype none

module lcd_host_model (
	// Serial link towards the driver.
	output var logic serial_clk_o,
	output var logic serial_data_o,
	output var logic load_o,
	output var logic blank_n_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// The serial clock only runs inside a word and stands low between words.
	initial begin
		serial_clk_o = 1'b0;
		serial_data_o = 1'b0;
		load_o = 1'b0;
		blank_n_o = 1'b0;
	end

	task automatic send_bit(input logic b);
		serial_data_o = b;
		#7.5 serial_clk_o = 1'b1;
		#7.5 serial_clk_o = 1'b0;
	endtask

	// Segment bits go first, then the dummy bits, then the select bits.
	task automatic send_word(input logic [79:0] seg, input logic [2:0] dummy, input logic [4:0] sel);
		#3.3;
		for (int i = 0; i < 80; i++) send_bit(seg[i]);
		for (int i = 0; i < 3; i++) send_bit(dummy[i]);
		for (int i = 0; i < 5; i++) send_bit(sel[i]);
		// Once hold time is over the data line no longer shows the last bit.
		serial_data_o = ~serial_data_o;
		#100 load_o = 1'b1;
		#100 load_o = 1'b0;
		#100;
	endtask

	task automatic set_blank(input logic v);
		blank_n_o = v;
	endtask
endmodule

`default_nettype wire

// ### testbench/test_serial_lcd_segment_mux_driver.sv
// Self-checking bench for the multiplexed LCD segment driver.
`default_nettype none

module test_serial_lcd_segment_mux_driver;
	timeunit 1ns;
	timeprecision 100ps;

	// A short oscillator divider keeps each common slot at 64 clock cycles.
	localparam int DIV  = 4;
	localparam int SLOT = 16 * DIV;

	logic                clk_i;
	logic                rst_i;
	logic                wb_cyc_i;
	logic                wb_stb_i;
	logic                wb_we_i;
	logic [3:0]          wb_adr_i;
	logic [3:0]          wb_sel_i;
	logic [31:0]         wb_dat_i;
	logic [31:0]         wb_dat_o;
	logic                wb_ack_o;
	logic                serial_clk;
	logic                serial_data;
	logic                load;
	logic                blank_n;
	logic [4:0][1:0]     common_out_o;
	logic [79:0][1:0]    segment_out_o;
	logic [79:0]         lat [5];
	logic                blk;
	logic [31:0]         q;
	int                  miscompares;
	int                  num_checks;
	int                  cycles;

	lcd_seg_driver #(.OSC_DIV_RESET(16'(DIV))) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .serial_clk_i(serial_clk), .serial_data_i(serial_data), .load_i(load),
		.blank_n_i(blank_n), .common_out_o(common_out_o), .segment_out_o(segment_out_o));

	lcd_host_model host (.serial_clk_o(serial_clk), .serial_data_o(serial_data), .load_o(load),
		.blank_n_o(blank_n));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic end_sim();
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic fail(input string m);
		miscompares++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail("run timeout");
			end_sim();
		end
	end

	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 40) fail("bus ack missing");
	endtask

	// Loads stay away from the scan checks so latch writes never land mid-sample.
	task automatic load_word(input logic [79:0] seg, input logic [2:0] dummy, input logic [4:0] sel);
		host.send_word(seg, dummy, sel);
		for (int k = 0; k < 5; k++) if (sel[k]) lat[k] = seg;
		repeat (6) @(posedge clk_i);
	endtask

	task automatic check_scan(input int n);
		int s, p, run, seen;
		logic hi, bad, lit, full;
		s = -1;
		run = 0;
		seen = 0;
		full = 1'b0;
		repeat (2 * n * SLOT + 80) begin
			@(negedge clk_i);
			p = s;
			s = -1;
			bad = 1'b0;
			for (int k = 0; k < 5; k++) if (common_out_o[k] === 2'h3 || common_out_o[k] === 2'h0) s = k;
			num_checks++;
			if (s < 0 || s >= n) begin
				fail("no valid common selected");
				continue;
			end
			hi = (common_out_o[s] === 2'h3);
			for (int k = 0; k < 5; k++) if (k != s && common_out_o[k] !== (hi ? 2'h1 : 2'h2)) bad = 1'b1;
			for (int j = 0; j < 80; j++) begin
				lit = lat[s][j] & ~blk;
				if (segment_out_o[j] !== (lit ? (hi ? 2'h0 : 2'h3) : (hi ? 2'h2 : 2'h1))) bad = 1'b1;
			end
			num_checks++;
			if (bad) fail("drive levels wrong");
			seen |= 1 << s;
			if (s == p) begin
				run++;
			end else begin
				num_checks++;
				if (full && run != SLOT) fail("common slot length wrong");
				full = (p >= 0);
				run = 1;
			end
		end
		num_checks++;
		if (seen != (1 << n) - 1) fail("commons scanned wrong");
	endtask

	task automatic t_regs();
		wb(1'b0, lcd_pkg::ADDR_CTRL, 32'h0000_0000);
		num_checks++;
		if (q[1:0] !== lcd_pkg::MODE_DUTY5) fail("mode reset wrong");
		wb(1'b0, lcd_pkg::ADDR_OSC_DIV, 32'h0000_0000);
		num_checks++;
		if (q[15:0] !== 16'(DIV)) fail("divider reset wrong");
		wb(1'b1, lcd_pkg::ADDR_OSC_DIV, 32'h0000_0000);
		wb(1'b0, lcd_pkg::ADDR_OSC_DIV, 32'h0000_0000);
		num_checks++;
		if (q !== 32'(lcd_pkg::OSC_DIV_MIN)) fail("zero divider not held at minimum");
		wb(1'b1, lcd_pkg::ADDR_OSC_DIV, 32'(DIV));
		wb(1'b1, 4'hC, 32'hFFFF_FFFF);
		wb(1'b0, 4'hC, 32'h0000_0000);
		num_checks++;
		if (q !== 32'h0000_0000) fail("unmapped read not zero");
	endtask

	task automatic t_blank();
		load_word({80{1'b1}}, 3'h0, 5'h01);
		check_scan(5);
		host.set_blank(1'b1);
		blk = 1'b0;
		repeat (6) @(posedge clk_i);
		check_scan(5);
	endtask

	task automatic t_select();
		for (int k = 0; k < 5; k++) load_word({10{8'(8'h11 * (k + 1))}}, 3'(k), 5'(1 << k));
		check_scan(5);
		load_word({5{16'hA5C3}}, 3'h7, 5'h16);
		check_scan(5);
	endtask

	task automatic t_modes();
		logic [1:0] code [4];
		int dn [4];
		code = '{2'h0, 2'h1, 2'h2, 2'h3};
		dn = '{3, 4, 5, 5};
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, lcd_pkg::ADDR_CTRL, 32'(code[i]));
			wb(1'b0, lcd_pkg::ADDR_CTRL, 32'h0000_0000);
			num_checks++;
			if (q[1:0] !== (i == 3 ? lcd_pkg::MODE_DUTY5 : code[i])) fail("mode readback wrong");
			repeat (4) @(posedge clk_i);
			check_scan(dn[i]);
		end
	endtask

	// A second reset in mid-run must clear the latches, the load count and the scan.
	task automatic t_reset();
		wb(1'b0, lcd_pkg::ADDR_STATUS, 32'h0000_0000);
		num_checks++;
		if (q[31:16] !== 16'h0007 || q[6:5] !== 2'h0) fail("status before reset wrong");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int k = 0; k < 5; k++) lat[k] = '0;
		wb(1'b0, lcd_pkg::ADDR_STATUS, 32'h0000_0000);
		num_checks++;
		if (q !== 32'h0000_0030) fail("status after reset wrong");
		repeat (4) @(posedge clk_i);
		check_scan(5);
	endtask

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		blk = 1'b1;
		miscompares = 0;
		num_checks = 0;
		for (int k = 0; k < 5; k++) lat[k] = '0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_blank();
		t_select();
		t_modes();
		t_reset();
		end_sim();
	end
endmodule

`default_nettype wire
